// file: src/mic_pkg.sv
package mic_pkg;

  // ******************************************************************
  // Widths and register map.
  // ******************************************************************
  localparam int        ADDR_W        = 8;
  localparam int        DATA_W        = 8;
  localparam int        PC_W          = 13;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PFLAG_A = 8'h01;
  localparam logic [7:0] ADDR_PEN_A   = 8'h02;
  localparam logic [7:0] ADDR_STAT    = 8'h03;
  localparam logic [7:0] ADDR_OPTION  = 8'h81;

  // ******************************************************************
  // Field positions.
  // ******************************************************************
  localparam int B_GIE  = 7;
  localparam int B_PEIE = 6;
  localparam int B_TWE  = 5;
  localparam int B_EXE  = 4;
  localparam int B_PCE  = 3;
  localparam int B_TWF  = 2;
  localparam int B_EXF  = 1;
  localparam int B_PCF  = 0;
  localparam int B_CONV = 0;
  localparam int B_EDGE = 6;
  localparam int B_ST_PEND  = 0;
  localparam int B_ST_WAKE  = 1;
  localparam int B_ST_EXPND = 2;

  // ******************************************************************
  // Reset values.
  // ******************************************************************
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] PFLAG_RST  = 8'h00;
  localparam logic [7:0] PEN_RST    = 8'h00;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;

  // ******************************************************************
  // Timing.
  // ******************************************************************
  localparam int         CLK_NS      = 20;
  localparam int         PHASE_NS    = 20;
  localparam int         PHASE_CYC   = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] LAT_WAIT_TCY = 2'h2;
  localparam logic [1:0] PRIME_CYC   = 2'h3;

  typedef enum logic [1:0] {
    PH_ONE   = 2'b00,
    PH_TWO   = 2'b01,
    PH_THREE = 2'b11,
    PH_FOUR  = 2'b10
  } mic_phase_t;

  typedef enum logic [1:0] {
    VS_IDLE = 2'b00,
    VS_WAIT = 2'b01,
    VS_VEC  = 2'b11
  } mic_vec_st_t;

  function automatic logic mic_pending(input logic [7:0] ctrl,
                                       input logic [7:0] pflag,
                                       input logic [7:0] pen);
    logic core_src;
    logic peri_src;
    core_src = (ctrl[B_TWF] & ctrl[B_TWE]) | (ctrl[B_EXF] & ctrl[B_EXE]) | (ctrl[B_PCF] & ctrl[B_PCE]);
    peri_src = ctrl[B_PEIE] & (|(pflag & pen));
    return core_src | peri_src;
  endfunction

endpackage

// file: src/mic_evt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mic_evt_if;
  import mic_pkg::*;
  logic       edge_sel;
  mic_phase_t phase;
  logic       ext_edge;
  logic       port_chg;
  modport src (input edge_sel, output phase, output ext_edge, output port_chg);
  modport sink (output edge_sel, input phase, input ext_edge, input port_chg);
endinterface
`default_nettype wire

// file: src/mic_event_front.sv
`timescale 1ns/10ps
`default_nettype none
module mic_event_front (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Pins
  input  wire logic       i_ext_pin,
  input  wire logic [3:0] i_port_hi,
  // Events
  mic_evt_if.src          evt
);
  import mic_pkg::*;

  logic       ext_s1_r,  ext_s2_r,  ext_d_r;
  logic [3:0] port_s1_r, port_s2_r, port_d_r;
  logic [1:0] prime_r,   prime_nxt;
  mic_phase_t phase_r,   phase_nxt;

  // ******************************************************************
  // Phase sequencer and synchronisers.
  // ******************************************************************
  always_comb begin
    case (phase_r)
      PH_ONE:   phase_nxt = PH_TWO;
      PH_TWO:   phase_nxt = PH_THREE;
      PH_THREE: phase_nxt = PH_FOUR;
      PH_FOUR:  phase_nxt = PH_ONE;
      default:  phase_nxt = PH_ONE;
    endcase
    prime_nxt = (prime_r == PRIME_CYC) ? prime_r : prime_r + 2'h1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_r   <= PH_ONE;
      prime_r   <= 2'h0;
      ext_s1_r  <= 1'b0;
      ext_s2_r  <= 1'b0;
      ext_d_r   <= 1'b0;
      port_s1_r <= 4'h0;
      port_s2_r <= 4'h0;
      port_d_r  <= 4'h0;
    end else begin
      phase_r   <= phase_nxt;
      prime_r   <= prime_nxt;
      ext_s1_r  <= i_ext_pin;
      ext_s2_r  <= ext_s1_r;
      ext_d_r   <= ext_s2_r;
      port_s1_r <= i_port_hi;
      port_s2_r <= port_s1_r;
      port_d_r  <= port_s2_r;
    end
  end

  // The history flops hold reset values until primed; no edge is reported before then.
  assign evt.phase    = phase_r;
  assign evt.ext_edge = (prime_r == PRIME_CYC) &
                        (evt.edge_sel ? (ext_s2_r & ~ext_d_r) : (~ext_s2_r & ext_d_r));
  assign evt.port_chg = (prime_r == PRIME_CYC) & (|(port_s2_r ^ port_d_r));

endmodule
`default_nettype wire

// file: src/mic_top.sv
`timescale 1ns/10ps
`default_nettype none
module mic_top #(
  parameter logic PORT_Q2_MISS = 1'b0
) (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rstn,
  // Register port
  input  wire logic [mic_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [mic_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [mic_pkg::DATA_W-1:0] o_rdata,
  // Pins
  input  wire logic                      i_ext_irq_pin,
  input  wire logic [3:0]                i_second_io_port_hi,
  // Event sources
  input  wire logic                      i_timer_wrap,
  input  wire logic                      i_conv_done,
  // Core
  input  wire logic [mic_pkg::PC_W-1:0]   i_pc,
  input  wire logic                      i_return_from_irq_op,
  input  wire logic                      i_asleep,
  input  wire logic                      i_port_read,
  output logic                           o_vector,
  output logic      [mic_pkg::PC_W-1:0]   o_vector_addr,
  output logic      [mic_pkg::PC_W-1:0]   o_ret_pc,
  output logic                           o_pop,
  output logic                           o_wake,
  output logic      [mic_pkg::DATA_W-1:0] o_option
);
  import mic_pkg::*;

  // ******************************************************************
  // Reset release.
  // ******************************************************************
  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // ******************************************************************
  // Event front end.
  // ******************************************************************
  mic_evt_if evt ();

  mic_event_front u_front (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_ext_pin (i_ext_irq_pin),
    .i_port_hi (i_second_io_port_hi),
    .evt       (evt)
  );

  // ******************************************************************
  // Registers and flags.
  // ******************************************************************
  logic [7:0]   ctrl_r,    ctrl_nxt;
  logic [7:0]   option_r,  option_nxt;
  logic [7:0]   pflag_r,   pflag_nxt;
  logic [7:0]   pen_r,     pen_nxt;
  logic         ext_pend_r, ext_pend_nxt;
  logic [7:0]   rdata_r,   rdata_nxt;
  logic         pop_r,     pop_nxt;
  mic_vec_st_t  st_r,      st_nxt;
  logic [1:0]   cnt_r,     cnt_nxt;
  logic [12:0]  ret_pc_r,  ret_pc_nxt;
  logic         ext_win;
  logic         ext_set;
  logic         pc_set;
  logic         pending;
  logic         req;
  logic         q1;

  assign evt.edge_sel = option_r[B_EDGE];
  assign q1           = (evt.phase == PH_ONE);
  assign ext_win      = (evt.phase == PH_FOUR) | q1;
  assign ext_set      = (ext_pend_r | evt.ext_edge) & ext_win;
  // The quirky variant drops a change that lands on a port read at phase two.
  assign pc_set       = evt.port_chg & ~(PORT_Q2_MISS & i_port_read & (evt.phase == PH_TWO));
  assign pending      = mic_pending(ctrl_r, pflag_r, pen_r);
  assign req          = ctrl_r[B_GIE] & pending & ~i_asleep;

  always_comb begin
    ctrl_nxt     = ctrl_r;
    option_nxt   = option_r;
    pflag_nxt    = pflag_r;
    pen_nxt      = pen_r;
    if (i_wr) begin
      case (i_addr)
        ADDR_CTRL:    ctrl_nxt   = i_wdata;
        ADDR_OPTION:  option_nxt = i_wdata;
        ADDR_PFLAG_A: pflag_nxt  = i_wdata & 8'h01;
        ADDR_PEN_A:   pen_nxt    = i_wdata;
        default:      ctrl_nxt   = ctrl_r;
      endcase
    end
    // Hardware sets win over a write in the same cycle; no clear on acknowledge.
    if (i_return_from_irq_op) begin
      ctrl_nxt[B_GIE] = 1'b1;
    end
    if (st_r == VS_VEC) begin
      ctrl_nxt[B_GIE] = 1'b0;
    end
    if (i_timer_wrap) begin
      ctrl_nxt[B_TWF] = 1'b1;
    end
    if (ext_set) begin
      ctrl_nxt[B_EXF] = 1'b1;
    end
    if (pc_set) begin
      ctrl_nxt[B_PCF] = 1'b1;
    end
    if (i_conv_done) begin
      pflag_nxt[B_CONV] = 1'b1;
    end
    ext_pend_nxt = (ext_pend_r | evt.ext_edge) & ~ext_win;
  end

  // ******************************************************************
  // Vector sequencer.
  // ******************************************************************
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    ret_pc_nxt = ret_pc_r;
    pop_nxt    = i_return_from_irq_op;
    case (st_r)
      VS_IDLE: begin
        if (q1 && req) begin
          st_nxt  = VS_WAIT;
          cnt_nxt = 2'h0;
        end
      end
      VS_WAIT: begin
        if (!req) begin
          st_nxt = VS_IDLE;
        end else if (q1) begin
          if (cnt_r == LAT_WAIT_TCY - 2'h1) begin
            st_nxt     = VS_VEC;
            ret_pc_nxt = i_pc;
          end else begin
            cnt_nxt = cnt_r + 2'h1;
          end
        end
      end
      VS_VEC:  st_nxt = VS_IDLE;
      default: st_nxt = VS_IDLE;
    endcase
  end

  // ******************************************************************
  // Read path.
  // ******************************************************************
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_rd) begin
      case (i_addr)
        ADDR_CTRL:    rdata_nxt = ctrl_r;
        ADDR_OPTION:  rdata_nxt = option_r;
        ADDR_PFLAG_A: rdata_nxt = pflag_r;
        ADDR_PEN_A:   rdata_nxt = pen_r;
        ADDR_STAT: begin
          rdata_nxt[B_ST_PEND]  = (st_r != VS_IDLE);
          rdata_nxt[B_ST_WAKE]  = o_wake;
          rdata_nxt[B_ST_EXPND] = ext_pend_r;
        end
        default:      rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r     <= CTRL_RST;
      option_r   <= OPTION_RST;
      pflag_r    <= PFLAG_RST;
      pen_r      <= PEN_RST;
      ext_pend_r <= 1'b0;
      rdata_r    <= 8'h00;
      pop_r      <= 1'b0;
      st_r       <= VS_IDLE;
      cnt_r      <= 2'h0;
      ret_pc_r   <= 13'h0000;
    end else begin
      ctrl_r     <= ctrl_nxt;
      option_r   <= option_nxt;
      pflag_r    <= pflag_nxt;
      pen_r      <= pen_nxt;
      ext_pend_r <= ext_pend_nxt;
      rdata_r    <= rdata_nxt;
      pop_r      <= pop_nxt;
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      ret_pc_r   <= ret_pc_nxt;
    end
  end

  // Wake ignores the global enable so the core can resume in line.
  assign o_wake        = i_asleep & pending;
  assign o_vector      = (st_r == VS_VEC);
  assign o_vector_addr = VECTOR_ADDR;
  assign o_ret_pc      = ret_pc_r;
  assign o_pop         = pop_r;
  assign o_rdata       = rdata_r;
  assign o_option      = option_r;

  // ******************************************************************
  // Checks.
  // ******************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  vec_clears_gie_a: assert property ((st_r == VS_VEC) && !i_return_from_irq_op |=> !ctrl_r[B_GIE])
    else $error("Global enable not cleared after vector.");
  ret_sets_gie_a: assert property (i_return_from_irq_op && (st_r != VS_VEC) |=> ctrl_r[B_GIE] && o_pop)
    else $error("Return did not set global enable.");
  timer_flag_a: assert property (i_timer_wrap |=> ctrl_r[B_TWF])
    else $error("Timer wrap flag not set.");
  conv_flag_a: assert property (i_conv_done |=> pflag_r[B_CONV])
    else $error("Converter flag not set.");
  ext_window_a: assert property ($rose(ctrl_r[B_EXF]) && !$past(i_wr) |-> $past(ext_win))
    else $error("Pin flag set outside phase four to one.");
  vec_gated_a: assert property ($rose(o_vector) |-> $past(ctrl_r[B_GIE]) && $past(pending))
    else $error("Vector without enabled request.");
  vec_latency_a: assert property ((st_r == VS_WAIT) && ($past(st_r) == VS_IDLE) ##0 req [*8] |=> o_vector)
    else $error("Vector latency wrong.");
  flag_hold_a: assert property (ctrl_r[B_EXF] && !i_wr |=> ctrl_r[B_EXF])
    else $error("Pin flag cleared without a write.");
  wake_a: assert property (i_asleep && ctrl_r[B_EXE] && ctrl_r[B_EXF] |-> o_wake && !o_vector)
    else $error("Enabled pin event did not wake.");

  vector_c: cover property (o_vector);
  wake_c: cover property (o_wake ##1 !i_asleep);
  return_c: cover property (o_vector ##[1:40] i_return_from_irq_op);
  ext_flag_c: cover property ($rose(ctrl_r[B_EXF]));

endmodule
`default_nettype wire

// file: dv/mic_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module mic_core_model
  import mic_pkg::*;
(
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rstn,
  // From the interrupt block
  input  wire logic            i_vector,
  input  wire logic [PC_W-1:0] i_vector_addr,
  input  wire logic [PC_W-1:0] i_ret_pc,
  input  wire logic            i_pop,
  // To the interrupt block
  output logic      [PC_W-1:0] o_pc,
  output logic                 o_ret_op,
  output logic                 o_asleep
);
  // ******************************************************************
  // Program counter and return stack.
  // ******************************************************************
  logic [PC_W-1:0] stack_q[$];
  logic [PC_W-1:0] last_pc;
  logic [PC_W-1:0] last_push;
  logic [PC_W-1:0] last_exp;

  // The counter keeps moving while awake so a stale return address is told apart.
  // Non-blocking updates keep the sampled return address free of edge races.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pc    <= 13'h0100;
      last_pc <= 13'h0000;
    end else if (i_vector) begin
      stack_q.push_back(i_ret_pc);
      last_push <= i_ret_pc;
      last_exp  <= last_pc;
      last_pc   <= o_pc;
      o_pc      <= i_vector_addr;
    end else begin
      last_pc <= o_pc;
      if (i_pop && stack_q.size() > 0) begin
        o_pc <= stack_q.pop_back();
      end else if (!o_asleep) begin
        o_pc <= o_pc + 13'h0001;
      end
    end
  end

  // ******************************************************************
  // Commands from the bench.
  // ******************************************************************
  task automatic do_return();
    @(posedge i_clk);
    o_ret_op <= 1'b1;
    @(posedge i_clk);
    o_ret_op <= 1'b0;
  endtask

  task automatic set_sleep(input logic v);
    @(posedge i_clk);
    o_asleep <= v;
  endtask

  initial begin
    o_ret_op = 1'b0;
    o_asleep = 1'b0;
  end
endmodule
`default_nettype wire

// file: dv/tb_mic_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_mic_top;
  import mic_pkg::*;
  // ******************************************************************
  // Signals.
  // ******************************************************************
  logic            i_clk, i_rstn, i_wr, i_rd, i_ext_irq_pin, i_timer_wrap, i_conv_done;
  logic            i_ret_op, i_asleep, o_vector, o_pop, o_wake;
  logic [7:0]      i_addr, i_wdata, o_rdata, o_option, rv;
  logic [3:0]      i_port_hi;
  logic [PC_W-1:0] i_pc, o_vector_addr, o_ret_pc;
  int              n_fail, comparisons, n, lo, hi;

  mic_top u_mic_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_irq_pin(i_ext_irq_pin), .i_second_io_port_hi(i_port_hi),
    .i_timer_wrap(i_timer_wrap), .i_conv_done(i_conv_done), .i_pc(i_pc), .i_return_from_irq_op(i_ret_op),
    .i_asleep(i_asleep), .i_port_read(1'b0), .o_vector(o_vector), .o_vector_addr(o_vector_addr),
    .o_ret_pc(o_ret_pc), .o_pop(o_pop), .o_wake(o_wake), .o_option(o_option));
  mic_core_model u_mic_core_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_vector(o_vector),
    .i_vector_addr(o_vector_addr), .i_ret_pc(o_ret_pc), .i_pop(o_pop), .o_pc(i_pc), .o_ret_op(i_ret_op),
    .o_asleep(i_asleep));

  // ******************************************************************
  // Bus and check tasks.
  // ******************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  // Waits for the vector pulse; n holds the cycles spent.
  task automatic wait_vec(input int lim);
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_vector !== 1'b1 && n < lim);
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // A full run needs well under 2000 cycles.
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    give_verdict();
  end

  // ******************************************************************
  // Tests.
  // ******************************************************************
  initial begin
    {i_rstn, i_wr, i_rd, i_ext_irq_pin, i_timer_wrap, i_conv_done} = 6'h00;
    {i_addr, i_wdata, i_port_hi} = 20'h00000;
    {n_fail, comparisons} = 0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    rdchk(ADDR_CTRL, CTRL_RST);
    rdchk(ADDR_OPTION, OPTION_RST);
    rdchk(ADDR_PFLAG_A, 8'h00);
    rdchk(ADDR_PEN_A, 8'h00);
    rdchk(8'h10, 8'h00);
    chk(o_vector_addr, VECTOR_ADDR);
    // All four sources at once, with every enable clear.
    @(posedge i_clk);
    {i_timer_wrap, i_conv_done, i_ext_irq_pin} <= 3'h7;
    i_port_hi <= 4'h8;
    @(posedge i_clk);
    {i_timer_wrap, i_conv_done} <= 2'h0;
    repeat (12) @(posedge i_clk);
    rdchk(ADDR_CTRL, 8'h07);
    rdchk(ADDR_PFLAG_A, 8'h01);
    rdchk(ADDR_CTRL, 8'h07);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_PFLAG_A, 8'h00);
    rdchk(ADDR_CTRL, 8'h00);
    rdchk(ADDR_PFLAG_A, 8'h00);
    for (int i = 0; i < 4; i++) begin
      i_port_hi <= i_port_hi ^ (4'h1 << i);
      repeat (8) @(posedge i_clk);
      rdchk(ADDR_CTRL, 8'h01);
      wr(ADDR_CTRL, 8'h00);
    end
    // Falling edge select, then a rising edge that must be ignored.
    wr(ADDR_OPTION, 8'hBF);
    i_ext_irq_pin <= 1'b0;
    repeat (10) @(posedge i_clk);
    chk(o_option, 8'hBF);
    rdchk(ADDR_CTRL, 8'h02);
    wr(ADDR_CTRL, 8'h00);
    i_ext_irq_pin <= 1'b1;
    repeat (10) @(posedge i_clk);
    rdchk(ADDR_CTRL, 8'h00);
    wr(ADDR_OPTION, 8'hFF);
    i_ext_irq_pin <= 1'b0;
    // Flags pending with their enables off must not vector.
    @(posedge i_clk);
    {i_timer_wrap, i_conv_done} <= 2'h3;
    @(posedge i_clk);
    {i_timer_wrap, i_conv_done} <= 2'h0;
    wr(ADDR_CTRL, 8'h84);
    wait_vec(30);
    chk(o_vector, 1'b0);
    wr(ADDR_PEN_A, 8'h01);
    wait_vec(30);
    chk(o_vector, 1'b0);
    wr(ADDR_CTRL, 8'hC4);
    wait_vec(30);
    chk(o_vector, 1'b1);
    repeat (2) @(posedge i_clk);
    chk(u_mic_core_model.last_push, u_mic_core_model.last_exp);
    rdchk(ADDR_CTRL, 8'h44);
    // Service clears the flags before the return re-enables.
    wr(ADDR_CTRL, 8'h40);
    wr(ADDR_PFLAG_A, 8'h00);
    u_mic_core_model.do_return();
    #1;
    chk(o_pop, 1'b1);
    rdchk(ADDR_CTRL, 8'hC0);
    wait_vec(20);
    chk(o_vector, 1'b0);
    // Pin latency from each phase offset.
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 8'h90);
      repeat (k) @(posedge i_clk);
      i_ext_irq_pin <= 1'b1;
      wait_vec(40);
      chk(o_vector, 1'b1);
      lo = (k == 0 || n < lo) ? n : lo;
      hi = (k == 0 || n > hi) ? n : hi;
      wr(ADDR_CTRL, 8'h00);
      i_ext_irq_pin <= 1'b0;
      repeat (6) @(posedge i_clk);
    end
    chk(hi - lo <= 4 && hi <= 18, 1'b1);
    // Wake from sleep with the global enable clear, then set.
    u_mic_core_model.set_sleep(1'b1);
    wr(ADDR_CTRL, 8'h02);
    @(posedge i_clk);
    #1;
    chk(o_wake, 1'b0);
    wr(ADDR_CTRL, 8'h10);
    i_ext_irq_pin <= 1'b1;
    repeat (10) @(posedge i_clk);
    #1;
    chk(o_wake, 1'b1);
    wr(ADDR_CTRL, 8'h92);
    wait_vec(30);
    chk(o_vector, 1'b0);
    u_mic_core_model.set_sleep(1'b0);
    wait_vec(30);
    chk(o_vector, 1'b1);
    // Software disables globally, then reads back once to check the enable is clear.
    wr(ADDR_CTRL, 8'h00);
    rdchk(ADDR_CTRL, 8'h00);
    // Reset in mid-run clears the global enable.
    wr(ADDR_CTRL, 8'h80);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    rdchk(ADDR_CTRL, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
